// >>> common/hw_monitor_cfg.svh
/*
 Constants of the hardware monitor sequencer: register offsets, field positions,
 reset values and timing counts.
 Assumes a 50 MHz system clock and word-aligned AHB-Lite register access.
*/
`ifndef HW_MONITOR_CFG_SVH
`define HW_MONITOR_CFG_SVH

// Register byte offsets (low address byte)
`define HWM_OFS_CONFIG 8'h00
`define HWM_OFS_FAN_DIV 8'h04
`define HWM_OFS_OVERTEMP 8'h08
`define HWM_OFS_HYST 8'h0C
`define HWM_OFS_STATUS 8'h10
`define HWM_OFS_RESULT_BASE 8'h80

// Configuration fields
`define HWM_CFG_RUN_BIT 0
`define HWM_CFG_HOLD_BIT 3
`define HWM_CFG_RESET 8'h08

// Fan divisor fields and reset value
`define HWM_DIV1_LSB 4
`define HWM_DIV2_LSB 6
`define HWM_FAN_DIV_RESET 8'h50
`define HWM_FAN3_DIV_CODE 2'h1

// Status fields
`define HWM_STAT_BUSY_BIT 0
`define HWM_STAT_OVER_BIT 1
`define HWM_STAT_ITEM_LSB 4

// Monitored items
`define HWM_ITEMS 11
`define HWM_FIRST_FAN 4'h8
`define HWM_LAST_ITEM 4'hA
`define HWM_FAN_SAT 8'hFF

// Timing
`define HWM_CLK_HZ 50000000
`define HWM_PASS_TIME_MS 1000
`define HWM_PASS_CYCLES ((`HWM_CLK_HZ / 1000) * `HWM_PASS_TIME_MS)
`define HWM_REF_HZ 22500
`define HWM_REF_CYCLES (`HWM_CLK_HZ / `HWM_REF_HZ)

`endif

// >>> common/hw_monitor_pkg.sv
/*
 Types of the hardware monitor sequencer: bus carriers, converter carriers,
 sequencer states and the module state record.
 Assumes hw_monitor_cfg.svh for all numeric constants.
*/
package hw_monitor_pkg;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahb_req_s;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } ahb_rsp_s;

   typedef struct packed {
      logic start;
      logic [2:0] channel;
   } adc_req_s;

   typedef struct packed {
      logic done;
      logic [7:0] code;
   } adc_rsp_s;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_ADC_START = 7'b0000010,
      ST_ADC_WAIT = 7'b0000100,
      ST_STORE = 7'b0001000,
      ST_FAN_ARM = 7'b0010000,
      ST_FAN_COUNT = 7'b0100000,
      ST_PASS_WAIT = 7'b1000000
   } seq_state_e;

   typedef struct packed {
      logic run;
      logic hold;
      logic [1:0] div1;
      logic [1:0] div2;
      logic signed [7:0] overtemp;
      logic signed [7:0] hyst;
      logic dp_valid;
      logic dp_write;
      logic [7:0] dp_addr;
      logic dp_mem;
      logic [31:0] rd;
      seq_state_e st;
      logic [3:0] item;
      logic [31:0] pass_cnt;
      logic [15:0] ref_cnt;
      logic [7:0] fan_cnt;
      logic [7:0] sample;
      logic temp_over;
      logic adc_start;
      logic [2:0] adc_chan;
      logic [2:0] tach1;
      logic [2:0] tach2;
      logic [2:0] tach3;
      logic [2:0] tach_lvl;
   } mon_state_s;

endpackage

// >>> hdl/result_memory.sv
/*
 Result memory: one word per monitored item, one write port, one registered
 read port.
 Assumes writes and reads share the system clock; read data appear one edge
 after the read index.
*/
`timescale 1ns/100ps
module result_memory #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 11
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Write port
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port
   input wire logic [3:0] rd_idx,
   output logic [WIDTH-1:0] rd_data
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rdata;
   } mem_state_s;

   mem_state_s s_q;
   mem_state_s s_d;

   if (DEPTH < 1 || DEPTH > 16 || WIDTH < 1) begin : g_check
      $error("result_memory: unsupported WIDTH or DEPTH");
   end

   always_comb begin
      s_d = s_q;
      if ({1'b0, rd_idx} < 5'(DEPTH)) begin
         s_d.rdata = s_q.mem[rd_idx];
      end else begin
         s_d.rdata = '0;
      end
      if (wr_en && {1'b0, wr_idx} < 5'(DEPTH)) begin
         s_d.mem[wr_idx] = wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q.rdata <= '0;
         s_q.mem <= s_d.mem;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rdata;

endmodule

// >>> hdl/hw_monitor_round_robin.sv
/*
 Round-robin monitoring sequencer with AHB-Lite register slave, fan tachometer
 counters and temperature setpoint comparator.
 Assumes an on-chip converter on the same clock (start pulse, done pulse, code)
 and asynchronous fan tachometer pins.
*/
`timescale 1ns/100ps
`include "hw_monitor_cfg.svh"
module hw_monitor_round_robin #(
   parameter int PASS_CYCLES = `HWM_PASS_CYCLES,
   parameter int REF_CYCLES = `HWM_REF_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // AHB-Lite slave
   input wire hw_monitor_pkg::ahb_req_s ahb_req,
   output hw_monitor_pkg::ahb_rsp_s ahb_rsp,
   // Converter
   output hw_monitor_pkg::adc_req_s adc_req,
   input wire hw_monitor_pkg::adc_rsp_s adc_rsp,
   // Fan tachometer pins
   input wire logic [2:0] fan_tach,
   // Status outputs
   output logic temp_alarm,
   output logic shutdown
);
   import hw_monitor_pkg::*;

   mon_state_s s_q;
   mon_state_s s_d;

   logic addr_taken;
   logic rd_taken_mem;
   logic [7:0] rd_mem_word;
   logic [3:0] rd_idx;
   logic mem_wr_en;
   logic go;
   logic [2:0] tach_edge;
   logic cur_edge;
   logic tick;
   logic [1:0] cur_div;
   logic [15:0] tick_limit;
   logic [31:0] wr_word;

   if (PASS_CYCLES < 64 || REF_CYCLES < 2 || REF_CYCLES > 8191) begin : g_check
      $error("hw_monitor_round_robin: unsupported PASS_CYCLES or REF_CYCLES");
   end

   // Byte address of a result slot
   function automatic logic [7:0] result_ofs(input logic [3:0] idx);
      result_ofs = `HWM_OFS_RESULT_BASE + {2'h0, idx, 2'h0};
   endfunction

   // Register read value seen through the bus
   function automatic logic [31:0] reg_value(input logic [7:0] ofs, input mon_state_s v);
      logic [31:0] r;
      r = 32'h0;
      case (ofs)
         `HWM_OFS_CONFIG: begin
            r[`HWM_CFG_RUN_BIT] = v.run;
            r[`HWM_CFG_HOLD_BIT] = v.hold;
         end
         `HWM_OFS_FAN_DIV: begin
            r[`HWM_DIV1_LSB +: 2] = v.div1;
            r[`HWM_DIV2_LSB +: 2] = v.div2;
         end
         `HWM_OFS_OVERTEMP: begin
            r[7:0] = v.overtemp;
         end
         `HWM_OFS_HYST: begin
            r[7:0] = v.hyst;
         end
         `HWM_OFS_STATUS: begin
            r[`HWM_STAT_BUSY_BIT] = (v.st != ST_IDLE);
            r[`HWM_STAT_OVER_BIT] = v.temp_over;
            r[`HWM_STAT_ITEM_LSB +: 4] = v.item;
         end
         default: begin
            r = 32'h0;
         end
      endcase
      reg_value = r;
   endfunction

   // Address phase decode
   assign addr_taken = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
   assign rd_idx = ahb_req.haddr[5:2];
   assign rd_taken_mem = addr_taken && !ahb_req.hwrite
      && ahb_req.haddr[7:0] >= `HWM_OFS_RESULT_BASE
      && ahb_req.haddr[7:0] <= result_ofs(`HWM_LAST_ITEM)
      && ahb_req.haddr[1:0] == 2'h0;
   assign wr_word = ahb_req.hwdata;

   // Agreed tachometer level rises once stages two and three match high
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         tach_edge[i] = (s_q.tach2[i] == s_q.tach3[i]) && s_q.tach3[i] && !s_q.tach_lvl[i];
      end
   end

   // Fan 3 divisor is fixed
   always_comb begin
      case (s_q.item)
         4'h8: cur_div = s_q.div1;
         4'h9: cur_div = s_q.div2;
         default: cur_div = `HWM_FAN3_DIV_CODE;
      endcase
   end

   // Reference prescaled by 1, 2, 4 or 8
   assign tick_limit = (16'(REF_CYCLES) << cur_div) - 16'h1;
   assign tick = (s_q.ref_cnt == tick_limit);

   always_comb begin
      case (s_q.item)
         4'h8: cur_edge = tach_edge[0];
         4'h9: cur_edge = tach_edge[1];
         default: cur_edge = tach_edge[2];
      endcase
   end

   assign go = s_q.run && !s_q.hold;
   assign mem_wr_en = (s_q.st == ST_STORE);

   always_comb begin
      s_d = s_q;
      s_d.adc_start = 1'b0;

      // Tachometer synchronisers
      s_d.tach1 = fan_tach;
      s_d.tach2 = s_q.tach1;
      s_d.tach3 = s_q.tach2;
      for (int i = 0; i < 3; i++) begin
         if (s_q.tach2[i] == s_q.tach3[i]) begin
            s_d.tach_lvl[i] = s_q.tach3[i];
         end
      end

      // Data phase write
      if (s_q.dp_valid && s_q.dp_write) begin
         case (s_q.dp_addr)
            `HWM_OFS_CONFIG: begin
               s_d.run = wr_word[`HWM_CFG_RUN_BIT];
               s_d.hold = wr_word[`HWM_CFG_HOLD_BIT];
            end
            `HWM_OFS_FAN_DIV: begin
               s_d.div1 = wr_word[`HWM_DIV1_LSB +: 2];
               s_d.div2 = wr_word[`HWM_DIV2_LSB +: 2];
            end
            `HWM_OFS_OVERTEMP: begin
               s_d.overtemp = wr_word[7:0];
            end
            `HWM_OFS_HYST: begin
               s_d.hyst = wr_word[7:0];
            end
            default: begin
            end
         endcase
      end

      // Address phase capture; read value sees a write just completed
      s_d.dp_valid = addr_taken;
      s_d.dp_write = addr_taken && ahb_req.hwrite;
      s_d.dp_addr = ahb_req.haddr[7:0];
      s_d.dp_mem = rd_taken_mem;
      if (addr_taken && !ahb_req.hwrite) begin
         s_d.rd = reg_value(ahb_req.haddr[7:0], s_d);
      end

      // Pass timer
      if (s_q.st != ST_IDLE) begin
         s_d.pass_cnt = s_q.pass_cnt + 32'h1;
      end

      // Sequencer
      case (s_q.st)
         ST_IDLE: begin
            if (go) begin
               s_d.item = 4'h0;
               s_d.pass_cnt = 32'h0;
               s_d.st = ST_ADC_START;
            end
         end
         ST_ADC_START: begin
            s_d.adc_start = 1'b1;
            s_d.adc_chan = s_q.item[2:0];
            s_d.st = ST_ADC_WAIT;
         end
         ST_ADC_WAIT: begin
            if (adc_rsp.done) begin
               s_d.sample = adc_rsp.code;
               s_d.st = ST_STORE;
            end else if (rd_taken_mem) begin
               s_d.st = ST_ADC_START;
            end
         end
         ST_STORE: begin
            if (s_q.item == 4'h0) begin
               if ($signed(s_q.sample) > s_q.overtemp) begin
                  s_d.temp_over = 1'b1;
               end else if ($signed(s_q.sample) < s_q.hyst) begin
                  s_d.temp_over = 1'b0;
               end
            end
            s_d.ref_cnt = 16'h0;
            s_d.fan_cnt = 8'h0;
            if (s_q.item == `HWM_LAST_ITEM) begin
               s_d.st = ST_PASS_WAIT;
            end else begin
               s_d.item = s_q.item + 4'h1;
               if (s_q.item + 4'h1 >= `HWM_FIRST_FAN) begin
                  s_d.st = ST_FAN_ARM;
               end else begin
                  s_d.st = ST_ADC_START;
               end
            end
         end
         ST_FAN_ARM: begin
            s_d.ref_cnt = tick ? 16'h0 : s_q.ref_cnt + 16'h1;
            if (cur_edge) begin
               s_d.ref_cnt = 16'h0;
               s_d.fan_cnt = 8'h0;
               s_d.st = ST_FAN_COUNT;
            end else if (tick) begin
               if (s_q.fan_cnt == `HWM_FAN_SAT) begin
                  s_d.sample = `HWM_FAN_SAT;
                  s_d.st = ST_STORE;
               end else begin
                  s_d.fan_cnt = s_q.fan_cnt + 8'h1;
               end
            end
         end
         ST_FAN_COUNT: begin
            s_d.ref_cnt = tick ? 16'h0 : s_q.ref_cnt + 16'h1;
            if (cur_edge) begin
               s_d.sample = s_q.fan_cnt;
               s_d.st = ST_STORE;
            end else if (tick) begin
               if (s_q.fan_cnt == `HWM_FAN_SAT) begin
                  s_d.sample = `HWM_FAN_SAT;
                  s_d.st = ST_STORE;
               end else begin
                  s_d.fan_cnt = s_q.fan_cnt + 8'h1;
               end
            end
         end
         ST_PASS_WAIT: begin
            if (s_q.pass_cnt >= 32'(PASS_CYCLES - 1)) begin
               s_d.item = 4'h0;
               s_d.pass_cnt = 32'h0;
               s_d.st = ST_ADC_START;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase

      // Stop or halt overrides the loop
      if (!go) begin
         s_d.st = ST_IDLE;
         s_d.adc_start = 1'b0;
         s_d.pass_cnt = 32'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q.run <= 1'b0;
         s_q.hold <= 1'b1;
         s_q.div1 <= 2'h1;
         s_q.div2 <= 2'h1;
         s_q.overtemp <= 8'h00;
         s_q.hyst <= 8'h00;
         s_q.dp_valid <= 1'b0;
         s_q.dp_write <= 1'b0;
         s_q.dp_addr <= 8'h00;
         s_q.dp_mem <= 1'b0;
         s_q.rd <= 32'h0;
         s_q.st <= ST_IDLE;
         s_q.item <= 4'h0;
         s_q.pass_cnt <= 32'h0;
         s_q.ref_cnt <= 16'h0;
         s_q.fan_cnt <= 8'h00;
         s_q.sample <= 8'h00;
         s_q.temp_over <= 1'b0;
         s_q.adc_start <= 1'b0;
         s_q.adc_chan <= 3'h0;
         s_q.tach1 <= 3'h0;
         s_q.tach2 <= 3'h0;
         s_q.tach3 <= 3'h0;
         s_q.tach_lvl <= 3'h0;
      end else begin
         s_q <= s_d;
      end
   end

   // Result slots, one per item in visiting order
   result_memory #(
      .WIDTH(8),
      .DEPTH(`HWM_ITEMS)
   ) u_results (
      .clk(clk),
      .resetn(resetn),
      .wr_en(mem_wr_en),
      .wr_idx(s_q.item),
      .wr_data(s_q.sample),
      .rd_idx(rd_idx),
      .rd_data(rd_mem_word)
   );

   always_comb begin
      ahb_rsp.hreadyout = 1'b1;
      ahb_rsp.hresp = 1'b0;
      ahb_rsp.hrdata = s_q.dp_mem ? {24'h0, rd_mem_word} : s_q.rd;
   end

   assign adc_req.start = s_q.adc_start;
   assign adc_req.channel = s_q.adc_chan;
   assign temp_alarm = s_q.temp_over;
   assign shutdown = !s_q.run;

endmodule

// >>> testbench/hw_monitor_chk.sv
/*
 Checker of the monitoring sequencer ports.
 Assumes it is bound to the sequencer top.
*/
`timescale 1ns/100ps
`include "hw_monitor_cfg.svh"
module hwm_checker #(
   parameter int PASS_CYCLES = 2000,
   parameter int REF_CYCLES = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register bus
   input wire hw_monitor_pkg::ahb_req_s ahb_req,
   input wire hw_monitor_pkg::ahb_rsp_s ahb_rsp,
   // Converter
   input wire hw_monitor_pkg::adc_req_s adc_req,
   input wire hw_monitor_pkg::adc_rsp_s adc_rsp,
   // Pins
   input wire logic [2:0] fan_tach,
   input wire logic temp_alarm,
   input wire logic shutdown
);
   import hw_monitor_pkg::*;
   logic rd_q;
   logic wr_q;
   logic [7:0] adr_q;
   logic [7:0] cfg_q;
   logic go;
   assign go = cfg_q[0] && !cfg_q[3];
   // Shadow of the configuration register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         adr_q <= 8'h00;
         cfg_q <= `HWM_CFG_RESET;
      end else begin
         rd_q <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && !ahb_req.hwrite;
         wr_q <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && ahb_req.hwrite;
         adr_q <= ahb_req.haddr[7:0];
         if (wr_q && adr_q == `HWM_OFS_CONFIG) begin
            cfg_q <= {4'h0, ahb_req.hwdata[3], 2'h0, ahb_req.hwdata[0]};
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_conv_done;
      adc_rsp.done && adc_req.channel != 3'h7 && go;
   endsequence
   sequence s_next_start;
      ##3 (!go || (adc_req.start && adc_req.channel == $past(adc_req.channel, 2) + 3'h1));
   endsequence
   a_item_order: assert property (s_conv_done |-> s_next_start)
      else $error("conversion order broken");
   a_bus_okay: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
      else $error("bus answer not ready or not okay");
   a_start_pulse: assert property (adc_req.start |=> !adc_req.start)
      else $error("start longer than one cycle");
   a_halt_quiet: assert property ((!go) [*3] |-> !adc_req.start)
      else $error("conversion started while halted");
   a_go_start: assert property ($rose(go) |-> ##[1:6] (adc_req.start && adc_req.channel == 3'h0))
      else $error("loop did not start at item 0");
   a_shut_track: assert property ($changed(cfg_q[0]) |-> ##[0:2] (shutdown == !cfg_q[0]))
      else $error("shutdown does not follow run bit");
   a_alarm_cause: assert property ($changed(temp_alarm) |->
      ($past(adc_rsp.done && adc_req.channel == 3'h0, 1) || $past(adc_rsp.done && adc_req.channel == 3'h0, 2)))
      else $error("alarm changed without a temperature result");
   a_cfg_read: assert property (rd_q && adr_q == `HWM_OFS_CONFIG |-> ahb_rsp.hrdata == {24'h0, cfg_q})
      else $error("configuration read wrong");
   a_upper_zero: assert property (rd_q |-> ahb_rsp.hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
endmodule
bind hw_monitor_round_robin hwm_checker #(.PASS_CYCLES(PASS_CYCLES), .REF_CYCLES(REF_CYCLES)) u_chk (
   .clk(clk), .resetn(resetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .adc_req(adc_req),
   .adc_rsp(adc_rsp), .fan_tach(fan_tach), .temp_alarm(temp_alarm), .shutdown(shutdown));

// >>> testbench/hwm_far_model.sv
/*
 Far side: converter answering after a channel-dependent delay, three tachometers.
 Assumes one shared clock; a half period of 0 stops a fan.
*/
`timescale 1ns/100ps
module hwm_far_model (
   // Clock
   input wire logic clk,
   // Converter
   input wire hw_monitor_pkg::adc_req_s adc_req,
   output hw_monitor_pkg::adc_rsp_s adc_rsp,
   // Settings
   input wire logic [7:0] temp_code,
   input wire logic [2:0][15:0] half,
   // Tachometer pins
   output logic [2:0] fan_tach
);
   import hw_monitor_pkg::*;
   logic busy = 1'b0;
   logic [7:0] cnt = 8'h00;
   logic [2:0][15:0] tc = '0;
   initial adc_rsp = '0;
   initial fan_tach = 3'h0;
   always @(posedge clk) begin
      adc_rsp.done <= 1'b0;
      // Stale code toggles outside done
      adc_rsp.code <= ~adc_rsp.code;
      if (adc_req.start) begin
         busy <= 1'b1;
         cnt <= 8'h0A + {2'h0, adc_req.channel, 3'h0};
      end else if (busy && cnt == 8'h00) begin
         busy <= 1'b0;
         adc_rsp.done <= 1'b1;
         adc_rsp.code <= adc_req.channel == 3'h0 ? temp_code : 8'h40 + {5'h0, adc_req.channel};
      end else if (busy) begin
         cnt <= cnt - 8'h01;
      end
      for (int i = 0; i < 3; i++) begin
         tc[i] <= (half[i] == 16'h0 || tc[i] + 16'h1 >= half[i]) ? 16'h0 : tc[i] + 16'h1;
         if (half[i] != 16'h0 && tc[i] + 16'h1 >= half[i])
            fan_tach[i] <= ~fan_tach[i];
      end
   end
endmodule

// >>> testbench/tb.sv
/*
 Self-checking bench of the monitoring sequencer.
 Assumes the far-side model and the bound checker.
*/
`timescale 1ns/100ps
`include "hw_monitor_cfg.svh"
module tb;
   import hw_monitor_pkg::*;
   localparam int PASS = 4000;
   localparam int REF = 4;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   ahb_req_s req = '{hready: 1'b1, default: '0};
   ahb_rsp_s rsp;
   adc_req_s areq;
   adc_rsp_s arsp;
   logic [2:0] tach;
   logic temp_alarm;
   logic shutdown;
   logic [7:0] tcode = 8'h7D;
   logic [2:0][15:0] half = {16'h00C8, 16'h0000, 16'h00C8};
   logic [31:0] v;
   int miscompares = 0;
   int checks_done = 0;
   int starts = 0;
   int cyc = 0;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (areq.start === 1'b1)
         starts++;
   end
   always @(posedge clk) cyc <= cyc + 1;
   hw_monitor_round_robin #(.PASS_CYCLES(PASS), .REF_CYCLES(REF)) u_dut (
      .clk(clk), .resetn(resetn), .ahb_req(req), .ahb_rsp(rsp), .adc_req(areq),
      .adc_rsp(arsp), .fan_tach(tach), .temp_alarm(temp_alarm), .shutdown(shutdown));
   hwm_far_model u_far (.clk(clk), .adc_req(areq), .adc_rsp(arsp), .temp_code(tcode), .half(half),
      .fan_tach(tach));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e, input int t = 0);
      checks_done++;
      if (t == 0 ? s !== e : (^s === 1'bx || s + t < e || s > e + t)) begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
      int n = 0;
      req.hsel <= 1'b1;
      req.htrans <= 2'h2;
      req.haddr <= {24'h0, a};
      req.hwrite <= w;
      req.hsize <= 3'h2;
      do @(posedge clk); while (rsp.hreadyout !== 1'b1 && ++n < 50);
      req.hsel <= 1'b0;
      req.htrans <= 2'h0;
      req.hwdata <= wd;
      do @(posedge clk); while (rsp.hreadyout !== 1'b1 && ++n < 50);
      q = rsp.hrdata;
      if (n >= 50) begin
         miscompares++;
         finish_test;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   task automatic wait_pass;
      int n = 0;
      do @(posedge clk); while (!(areq.start === 1'b1 && areq.channel === 3'h0) && ++n < 3 * PASS);
      if (n >= 3 * PASS) begin
         miscompares++;
         finish_test;
      end
   endtask
   task automatic t_reset;
      check("shutdown", {31'h0, shutdown}, 32'h1);
      rd(`HWM_OFS_CONFIG, v);
      check("config", v, 32'h8);
      rd(`HWM_OFS_FAN_DIV, v);
      check("fan_div", v & 32'hF0, 32'h50);
      wr(8'h40, 32'hFF);
      rd(8'h40, v);
      check("unmapped", v, 32'h0);
   endtask
   task automatic t_setpoint;
      logic [7:0] t [2] = '{8'hC9, 8'h7D};
      foreach (t[i]) begin
         wr(`HWM_OFS_OVERTEMP, {24'h0, t[i]});
         wr(`HWM_OFS_HYST, {24'h0, ~t[i]});
         rd(`HWM_OFS_OVERTEMP, v);
         check("overtemp", v, {24'h0, t[i]});
         rd(`HWM_OFS_HYST, v);
         check("hyst", v, {24'h0, ~t[i]});
      end
      wr(`HWM_OFS_OVERTEMP, 32'h19);
      wr(`HWM_OFS_HYST, 32'hE7);
   endtask
   task automatic t_hold;
      int s;
      wr(`HWM_OFS_CONFIG, 32'h9);
      s = starts;
      repeat (50) @(posedge clk);
      check("held", starts, s);
      check("shutdown", {31'h0, shutdown}, 32'h0);
      wr(`HWM_OFS_CONFIG, 32'h1);
      wait_pass;
      s = cyc;
      wait_pass;
      check("pass_len", cyc - s, PASS);
   endtask
   task automatic t_loop;
      logic [7:0] tv [2] = '{8'h7D, 8'hC9};
      foreach (tv[k]) begin
         tcode <= tv[k];
         // Wait two cycles after setting the new temperature code before the passes
         repeat (2) @(posedge clk);
         wait_pass;
         wait_pass;
         for (int i = 0; i < 8; i++) begin
            rd(`HWM_OFS_RESULT_BASE + 8'(4 * i), v);
            check("result", v, {24'h0, i == 0 ? tv[k] : 8'(8'h40 + i)});
         end
         check("alarm", {31'h0, temp_alarm}, {31'h0, k == 0});
         rd(`HWM_OFS_STATUS, v);
         check("status", v & 32'h3, {30'h0, k == 0, 1'b1});
      end
   endtask
   task automatic t_fans;
      for (int c = 0; c < 4; c++) begin
         wr(`HWM_OFS_FAN_DIV, 32'(c << 4));
         wait_pass;
         wait_pass;
         rd(`HWM_OFS_FAN_DIV, v);
         check("fan_div", v & 32'hF0, 32'(c << 4));
         rd(`HWM_OFS_RESULT_BASE + 8'h20, v);
         check("fan1", v, 32'(400 / (REF << c)), 1);
         rd(`HWM_OFS_RESULT_BASE + 8'h24, v);
         check("fan2", v, 32'hFF);
         rd(`HWM_OFS_RESULT_BASE + 8'h28, v);
         check("fan3", v, 32'(400 / (REF << 1)), 1);
      end
   endtask
   task automatic t_stop;
      int s;
      wr(`HWM_OFS_CONFIG, 32'h0);
      repeat (2) @(posedge clk);
      s = starts;
      repeat (100) @(posedge clk);
      check("stopped", starts, s);
      check("shutdown", {31'h0, shutdown}, 32'h1);
      rd(`HWM_OFS_HYST, v);
      check("hyst", v, 32'hE7);
      rd(`HWM_OFS_STATUS, v);
      check("idle", v & 32'h3, 32'h0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset;
      t_setpoint;
      t_hold;
      t_loop;
      t_fans;
      t_stop;
      finish_test;
   end
endmodule
